// File: bench/i2c_mode_pin_irq_routing_monitor.sv
`timescale 1ns/100ps
module i2c_mode_pin_irq_routing_monitor (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       two_wire_mode_select,
  input wire logic [3:0] dma_channel_one_req_select,
  input wire logic       serial_active,
  input wire logic       serial_scl_out,
  input wire logic       cpu_latch_wr,
  input wire logic [7:0] cpu_latch_wdata,
  input wire logic       cpu_bit_wr,
  input wire logic [2:0] cpu_bit_idx,
  input wire logic       cpu_bit_val,
  input wire logic [7:0] port_latch_out,
  input wire logic [7:0] port_dir_out,
  input wire logic       irq_src_a,
  input wire logic       irq_src_c,
  input wire logic       dma_channel_one_req,
  input wire logic       two_wire_active,
  input wire logic [7:0] port_pin_out,
  input wire logic [7:0] port_pin_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  a_mode_follows: assert property (
    !$past(sys_rst) |-> two_wire_active == $past(two_wire_mode_select)) else $error("mode register wrong");
  a_ordinary_pins: assert property (
    !two_wire_active |=> port_pin_oe[0] && !port_pin_oe[1]) else $error("ordinary pin drive wrong");
  a_ordinary_idle_high: assert property (
    !two_wire_active && !serial_active |=> port_pin_out[0]) else $error("data pin not idle high");
  a_sda_idle_latch: assert property (
    two_wire_active && !serial_active |=> !port_pin_out[0] && port_pin_oe[0] == !$past(port_latch_out[0]))
    else $error("idle data pin ignores latch");
  a_scl_open_drain: assert property (
    two_wire_active && serial_active |=> port_pin_oe[1] == !$past(serial_scl_out)) else $error("clock pin drive wrong");
  a_bit2_plain: assert property (
    two_wire_active |=> port_pin_oe[2] == $past(port_dir_out[2]) && port_pin_out[2] == $past(port_latch_out[2]))
    else $error("bit two not a plain port");
  a_irq_one_cycle: assert property (
    $rose(irq_src_a) |=> !irq_src_a) else $error("request longer than one cycle");
  a_dma_needs_c: assert property (
    dma_channel_one_req |-> irq_src_c) else $error("dma request without its cause");
  a_dma_selected: assert property (
    irq_src_c && $past(dma_channel_one_req_select, 2) == 4'hd
    |-> dma_channel_one_req) else $error("dma request missing");
  a_latch_write: assert property (
    cpu_latch_wr |=> port_latch_out == $past(cpu_latch_wdata)) else $error("byte write lost");
  // all outputs and ordinary mode: the whole latch comes back with only the target changed
  a_bit_write_out: assert property (
    cpu_bit_wr && !cpu_latch_wr && port_dir_out == 8'hff && !two_wire_active |=> port_latch_out ==
    (($past(port_latch_out) & ~(8'h01 << $past(cpu_bit_idx))) | ({7'h00, $past(cpu_bit_val)} << $past(cpu_bit_idx))))
    else $error("bit write disturbed latch");
endmodule // i2c_mode_pin_irq_routing_monitor

bind i2c_mode_pin_irq_routing i2c_mode_pin_irq_routing_monitor mon_u (
  .clk, .sys_rst, .two_wire_mode_select, .dma_channel_one_req_select, .serial_active, .serial_scl_out,
  .cpu_latch_wr, .cpu_latch_wdata, .cpu_bit_wr, .cpu_bit_idx, .cpu_bit_val, .port_latch_out, .port_dir_out,
  .irq_src_a, .irq_src_c, .dma_channel_one_req, .two_wire_active, .port_pin_out, .port_pin_oe);

// File: bench/i2c_mode_pin_irq_routing_tb_top.sv
`timescale 1ns/100ps
module i2c_mode_pin_irq_routing_tb_top;
  logic       clk = '0, link_clk = '0, sys_rst = '1;
  logic       two_wire_mode_select = '0, two_wire_irq_source_select = '0, serial_active = '0;
  logic       serial_transmit_out = '1, serial_sda_out = '1, serial_scl_out = '1;
  logic       serial_clock_out = '0, serial_clock_oe = '0;
  logic       cpu_latch_wr = '0, cpu_dir_wr = '0, cpu_bit_wr = '0, cpu_bit_val = '0;
  logic [2:0] cpu_bit_idx = '0;
  logic [3:0] dma_channel_one_req_select = '0, seen;
  logic [5:0] link_evt = '0;
  logic [7:0] cpu_latch_wdata = '0, cpu_dir_wdata = '0, port_pin_in, pull_low = '0, lf = 8'h2a;
  logic       serial_receive_in, serial_sda_in, serial_scl_in, serial_clock_pin_in;
  logic       irq_src_a, irq_src_b, irq_src_c, dma_channel_one_req, two_wire_active;
  logic [7:0] cpu_port_rdata, port_latch_out, port_dir_out, port_pin_out, port_pin_oe;
  int         fail_count = 0, n_tests = 0;

  always #10 clk = ~clk;
  // link clock offset so its edges never line up with the system clock
  initial begin
    #7;
    forever #80 link_clk = ~link_clk;
  end

  i2c_mode_pin_irq_routing dut_u (.clk, .sys_rst, .link_clk, .two_wire_mode_select, .two_wire_irq_source_select,
    .dma_channel_one_req_select, .link_evt, .serial_active, .serial_transmit_out, .serial_sda_out, .serial_scl_out,
    .serial_clock_out, .serial_clock_oe, .serial_receive_in, .serial_sda_in, .serial_scl_in,
    .serial_clock_pin_in, .cpu_latch_wr, .cpu_latch_wdata, .cpu_dir_wr, .cpu_dir_wdata, .cpu_bit_wr, .cpu_bit_idx,
    .cpu_bit_val, .cpu_port_rdata, .port_latch_out, .port_dir_out, .irq_src_a, .irq_src_b, .irq_src_c,
    .dma_channel_one_req, .two_wire_active, .port_pin_in, .port_pin_out, .port_pin_oe);
  two_wire_bus_model bus_u (.pin_out(port_pin_out), .pin_oe(port_pin_oe), .pull_low, .pin_level(port_pin_in));
  ////////////////////////////////////////
  function automatic logic [7:0] rnd();
    lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
    return lf;
  endfunction
  // expected {dma, c, b, a} for one event line
  function automatic logic [3:0] route(input int e, input logic m, input logic s, input logic [3:0] d);
    logic [3:0] r;
    r[0] = m ? e == 0 : e == 1;
    r[1] = (m && !s) ? e == 2 : e == 4;
    r[2] = (m && !s) ? e == 3 : e == 5;
    r[3] = d == 4'hd && r[2];
    return r;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // k = {bit, dir, latch}; dat[2:0] and dat[3] double as bit index and value
  task automatic wr(input logic [2:0] k, input logic [7:0] dat);
    @(negedge clk);
    {cpu_bit_wr, cpu_dir_wr, cpu_latch_wr} = k;
    cpu_latch_wdata = dat;
    cpu_dir_wdata = dat;
    cpu_bit_idx = dat[2:0];
    cpu_bit_val = dat[3];
    @(negedge clk);
    {cpu_bit_wr, cpu_dir_wr, cpu_latch_wr} = 3'h0;
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    logic [7:0] r, d, l, v, s;
    repeat (3) @(posedge clk);
    @(negedge clk) sys_rst = '0;
    chk({port_latch_out | port_dir_out}, 8'h00, "latch and dir reset");
    chk({port_pin_oe}, 8'h00, "pins released");
    chk({4'h0, serial_receive_in, serial_sda_in, serial_scl_in, serial_clock_pin_in}, 8'h0f, "serial inputs idle");
    $display("reset test done");
    for (int k = 0; k < 8; k++) begin
      r = rnd();
      two_wire_mode_select = k[0];
      two_wire_irq_source_select = k[1];
      dma_channel_one_req_select = k[2] ? 4'hd : r[3:0];
      cyc(4);
      for (int e = 0; e < 6; e++) begin
        seen = '0;
        @(negedge link_clk) link_evt[e] = '1;
        // drop the event soon after the link edge takes it, so watching starts before the pulse
        @(posedge link_clk);
        @(negedge clk) link_evt = '0;
        repeat (12) @(negedge clk) seen |= {dma_channel_one_req, irq_src_c, irq_src_b, irq_src_a};
        chk({4'h0, seen}, {4'h0, route(e, k[0], k[1], dma_channel_one_req_select)}, "event route");
      end
    end
    $display("event routing test done");
    two_wire_mode_select = '1;
    wr(3'h1, 8'h01);
    cyc(3);
    chk({6'h00, port_pin_oe[0], port_pin_out[0]}, 8'h00, "idle data released");
    wr(3'h1, 8'h00);
    cyc(1);
    chk({6'h00, port_pin_oe[0], port_pin_out[0]}, 8'h02, "idle data low");
    serial_active = '1;
    serial_sda_out = '0;
    pull_low = 8'h02;
    cyc(4);
    chk({4'h0, port_pin_oe[1:0], serial_sda_in, serial_scl_in}, 8'h04, "two-wire pins");
    serial_active = '0;
    wr(3'h2, 8'h02);
    wr(3'h1, 8'h02);
    cyc(4);
    chk(cpu_port_rdata, 8'hfc, "clock pin read");
    wr(3'h4, 8'h0d);
    chk(port_latch_out, 8'hfc, "clock level captured");
    two_wire_mode_select = '0;
    wr(3'h1, 8'h02);
    cyc(4);
    chk(cpu_port_rdata, 8'hff, "ordinary read view");
    chk({3'h0, serial_receive_in, two_wire_active, port_pin_oe[1:0], port_pin_out[0]}, 8'h03, "ordinary pins");
    serial_active = '1;
    serial_transmit_out = '0;
    cyc(1);
    chk({7'h00, port_pin_out[0]}, 8'h00, "transmit pin");
    serial_active = '0;
    serial_clock_oe = '1;
    serial_clock_out = '0;
    cyc(4);
    chk({5'h00, port_pin_oe[2], port_pin_out[2], serial_clock_pin_in}, 8'h04, "clock pin drive");
    serial_clock_oe = '0;
    wr(3'h5, 8'h0f);
    chk(port_latch_out, 8'h0f, "byte write beats bit write");
    $display("pin function test done");
    for (int i = 0; i < 6; i++) begin
      d = i == 0 ? 8'hff : rnd();
      l = rnd();
      s = rnd();
      wr(3'h2, d);
      wr(3'h1, l);
      pull_low = rnd();
      cyc(4);
      r = (((d & l) | ~d) | 8'h07) & ~pull_low;
      v = (d & l) | (~d & r);
      v[s[2:0]] = s[3];
      wr(3'h4, s);
      chk(port_latch_out, v, "bit write latch");
      cyc(1);
      chk(cpu_port_rdata, (d & v) | (~d & r), "read after bit write");
    end
    $display("read-modify-write test done");
    conclude();
  end
  // whole run needs about 25 us; a hang past eight times that is cut short
  initial begin
    #200000;
    fail_count++;
    $display("Error %0t: watchdog expired", $time);
    conclude();
  end
endmodule // i2c_mode_pin_irq_routing_tb_top

// File: bench/two_wire_bus_model.sv
`timescale 1ns/100ps
module two_wire_bus_model (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pull_low,
  output logic      [7:0] pin_level
);
  // every line has a pull-up, so a released line reads high unless a far device holds it low
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      pin_level[b] = (pin_oe[b] ? pin_out[b] : 1'h1) & ~pull_low[b];
    end
  end
endmodule // two_wire_bus_model

// File: design/i2c_mode_pin_irq_routing.sv
// Operation
// - mode bit 1 selects two-wire mode, 0 selects ordinary synchronous serial
// - two-wire: bit0 SDA, bit1 SCL, bit2 port; else transmit, receive, clock
// - two-wire idle data pin follows latch bit; ordinary mode data pin idles high
// - two-wire clock pin reads pin level; ordinary read follows direction register
// - source 10: start/stop in two-wire mode, bus collision otherwise
// - source 15: no-acknowledge in two-wire with selector 0, else transmission
// - source 16: acknowledge in two-wire with selector 0, else reception
// - dma one selector 1101: acknowledge in two-wire selector 0, else reception
// - bit writes to port latch are read-modify-write of the whole register
// - input bits read the pin during bit writes and store it in the latch
// - output bits read the latch during bit writes and keep it unchanged, except the two-wire clock bit, which reads the pin
`timescale 1ns/100ps
module i2c_mode_pin_irq_routing (
  input  wire logic                                     clk,
  input  wire logic                                     sys_rst,
  input  wire logic                                     link_clk,
  // configuration
  input  wire logic                                     two_wire_mode_select,
  input  wire logic                                     two_wire_irq_source_select,
  input  wire logic [two_wire_route_pkg::DMA_SEL_W-1:0] dma_channel_one_req_select,
  // serial datapath, link-side events (link_clk)
  input  wire logic [two_wire_route_pkg::EVT_N-1:0]     link_evt,
  // serial datapath, system side
  input  wire logic                                     serial_active,
  input  wire logic                                     serial_transmit_out,
  input  wire logic                                     serial_sda_out,
  input  wire logic                                     serial_scl_out,
  input  wire logic                                     serial_clock_out,
  input  wire logic                                     serial_clock_oe,
  output logic                                          serial_receive_in,
  output logic                                          serial_sda_in,
  output logic                                          serial_scl_in,
  output logic                                          serial_clock_pin_in,
  // cpu port access
  input  wire logic                                     cpu_latch_wr,
  input  wire logic [two_wire_route_pkg::PORT_W-1:0]    cpu_latch_wdata,
  input  wire logic                                     cpu_dir_wr,
  input  wire logic [two_wire_route_pkg::PORT_W-1:0]    cpu_dir_wdata,
  input  wire logic                                     cpu_bit_wr,
  input  wire logic [2:0]                               cpu_bit_idx,
  input  wire logic                                     cpu_bit_val,
  output logic [two_wire_route_pkg::PORT_W-1:0]         cpu_port_rdata,
  output logic [two_wire_route_pkg::PORT_W-1:0]         port_latch_out,
  output logic [two_wire_route_pkg::PORT_W-1:0]         port_dir_out,
  // interrupt and dma requests
  output logic                                          irq_src_a,
  output logic                                          irq_src_b,
  output logic                                          irq_src_c,
  output logic                                          dma_channel_one_req,
  output logic                                          two_wire_active,
  // port seven pins
  input  wire logic [two_wire_route_pkg::PORT_W-1:0]    port_pin_in,
  output logic [two_wire_route_pkg::PORT_W-1:0]         port_pin_out,
  output logic [two_wire_route_pkg::PORT_W-1:0]         port_pin_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  two_wire_route_pkg::serial_mode_t          mode_reg;
  logic                                      irq_sel_reg;
  logic [two_wire_route_pkg::DMA_SEL_W-1:0]  dma_sel_reg;

  logic [two_wire_route_pkg::PORT_W-1:0]     pin_meta_reg;
  logic [two_wire_route_pkg::PORT_W-1:0]     pin_sync_reg;

  logic [two_wire_route_pkg::PORT_W-1:0]     port_latch_reg;
  logic [two_wire_route_pkg::PORT_W-1:0]     port_dir_reg;
  logic [two_wire_route_pkg::PORT_W-1:0]     latch_next;

  logic [two_wire_route_pkg::PORT_W-1:0]     base_view;
  logic [two_wire_route_pkg::PORT_W-1:0]     read_view;
  logic [two_wire_route_pkg::PORT_W-1:0]     rmw_value;
  logic [two_wire_route_pkg::PORT_W-1:0]     rdata_reg;

  logic [two_wire_route_pkg::PORT_W-1:0]     gen_out;
  logic [two_wire_route_pkg::PORT_W-1:0]     gen_oe;
  logic [two_wire_route_pkg::PORT_W-1:0]     pin_out_next;
  logic [two_wire_route_pkg::PORT_W-1:0]     pin_oe_next;
  logic [two_wire_route_pkg::PORT_W-1:0]     pin_out_reg;
  logic [two_wire_route_pkg::PORT_W-1:0]     pin_oe_reg;

  logic                                      sda_level;
  logic                                      scl_level;
  logic                                      is_two_wire;
  logic                                      ack_route;

  logic                                      irq_a_reg;
  logic                                      irq_b_reg;
  logic                                      irq_c_reg;
  logic                                      dma_reg;

  logic                                      rx_in_reg;
  logic                                      sda_in_reg;
  logic                                      scl_in_reg;
  logic                                      clk_in_reg;

  event_bus_if evt_bus ();

  ////////////////////////////////////////////////////////////////////////////
  // configuration capture

  // config bits come from logic on clk, so no synchroniser is needed
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_reg    <= two_wire_route_pkg::MODE_SYNC_SERIAL;
      irq_sel_reg <= 1'b0;
      dma_sel_reg <= '0;
    end else begin
      mode_reg    <= two_wire_mode_select ? two_wire_route_pkg::MODE_TWO_WIRE
                                          : two_wire_route_pkg::MODE_SYNC_SERIAL;
      irq_sel_reg <= two_wire_irq_source_select;
      dma_sel_reg <= dma_channel_one_req_select;
    end
  end

  assign is_two_wire = (mode_reg == two_wire_route_pkg::MODE_TWO_WIRE);
  // acknowledge events replace transmit/receive causes only in this corner
  assign ack_route   = is_two_wire && !irq_sel_reg;

  ////////////////////////////////////////////////////////////////////////////
  // pin input synchronisers

  genvar b;
  generate
    for (b = 0; b < two_wire_route_pkg::PORT_W; b = b + 1) begin : g_pin
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          pin_meta_reg[b] <= 1'b1;
          pin_sync_reg[b] <= 1'b1;
        end else begin
          pin_meta_reg[b] <= port_pin_in[b];
          pin_sync_reg[b] <= pin_meta_reg[b];
        end
      end

      // plain port behaviour, overridden below for the serial pins
      assign base_view[b] = port_dir_reg[b] ? port_latch_reg[b] : pin_sync_reg[b];
      assign gen_out[b]   = port_latch_reg[b];
      assign gen_oe[b]    = port_dir_reg[b];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // link event crossing

  link_event_sync u_evt_sync (
    .link_clk (link_clk),
    .clk      (clk),
    .sys_rst  (sys_rst),
    .link_evt (link_evt),
    .bus      (evt_bus.producer)
  );

  ////////////////////////////////////////////////////////////////////////////
  // interrupt and dma cause routing

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_a_reg <= 1'b0;
      irq_b_reg <= 1'b0;
      irq_c_reg <= 1'b0;
    end else begin
      irq_a_reg <= is_two_wire ? evt_bus.evt_pulse[two_wire_route_pkg::EVT_START_STOP]
                               : evt_bus.evt_pulse[two_wire_route_pkg::EVT_COLLISION];
      irq_b_reg <= ack_route ? evt_bus.evt_pulse[two_wire_route_pkg::EVT_NACK]
                             : evt_bus.evt_pulse[two_wire_route_pkg::EVT_TX];
      irq_c_reg <= ack_route ? evt_bus.evt_pulse[two_wire_route_pkg::EVT_ACK]
                             : evt_bus.evt_pulse[two_wire_route_pkg::EVT_RX];
    end
  end

  // other selector codes pick requests outside this block, so none here
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dma_reg <= 1'b0;
    end else if (dma_sel_reg == two_wire_route_pkg::DMA_SEL_SERIAL) begin
      dma_reg <= ack_route ? evt_bus.evt_pulse[two_wire_route_pkg::EVT_ACK]
                           : evt_bus.evt_pulse[two_wire_route_pkg::EVT_RX];
    end else begin
      dma_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cpu read view and read-modify-write

  always_comb begin
    read_view = base_view;
    if (is_two_wire) begin
      read_view[two_wire_route_pkg::SCL_BIT] = pin_sync_reg[two_wire_route_pkg::SCL_BIT];
    end
  end

  // the bit write reads the whole port first, so input bits pick up the pin
  // level and, in two-wire mode, the clock bit picks up the bus level too
  always_comb begin
    rmw_value = read_view;
    rmw_value[cpu_bit_idx] = cpu_bit_val;
  end

  always_comb begin
    latch_next = port_latch_reg;
    if (cpu_latch_wr) begin
      latch_next = cpu_latch_wdata;
    end else if (cpu_bit_wr) begin
      latch_next = rmw_value;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      port_latch_reg <= two_wire_route_pkg::LATCH_RST;
    end else begin
      port_latch_reg <= latch_next;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      port_dir_reg <= two_wire_route_pkg::DIR_RST;
    end else if (cpu_dir_wr) begin
      port_dir_reg <= cpu_dir_wdata;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= read_view;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin function multiplexing

  // open-drain levels: one releases the wire, zero pulls it low
  assign sda_level = serial_active ? serial_sda_out
                                   : port_latch_reg[two_wire_route_pkg::SDA_BIT];
  assign scl_level = serial_active ? serial_scl_out
                                   : port_latch_reg[two_wire_route_pkg::SCL_BIT];

  always_comb begin
    pin_out_next = gen_out;
    pin_oe_next  = gen_oe;
    if (is_two_wire) begin
      pin_out_next[two_wire_route_pkg::SDA_BIT] = 1'b0;
      pin_oe_next[two_wire_route_pkg::SDA_BIT]  = ~sda_level;
      pin_out_next[two_wire_route_pkg::SCL_BIT] = 1'b0;
      pin_oe_next[two_wire_route_pkg::SCL_BIT]  = ~scl_level;
    end else begin
      pin_out_next[two_wire_route_pkg::SDA_BIT]  = serial_active ? serial_transmit_out : 1'b1;
      pin_oe_next[two_wire_route_pkg::SDA_BIT]   = 1'b1;
      pin_out_next[two_wire_route_pkg::SCL_BIT]  = 1'b0;
      pin_oe_next[two_wire_route_pkg::SCL_BIT]   = 1'b0;
      pin_out_next[two_wire_route_pkg::CLKP_BIT] = serial_clock_out;
      pin_oe_next[two_wire_route_pkg::CLKP_BIT]  = serial_clock_oe;
    end
  end

  // registering the drive costs a cycle but keeps pin glitches off the bus
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_out_reg <= '0;
      pin_oe_reg  <= '0;
    end else begin
      pin_out_reg <= pin_out_next;
      pin_oe_reg  <= pin_oe_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial datapath input views

  // unused inputs park at the idle-high level so the shifter sees no edges
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_in_reg  <= 1'b1;
      sda_in_reg <= 1'b1;
      scl_in_reg <= 1'b1;
      clk_in_reg <= 1'b1;
    end else if (is_two_wire) begin
      rx_in_reg  <= 1'b1;
      sda_in_reg <= pin_sync_reg[two_wire_route_pkg::SDA_BIT];
      scl_in_reg <= pin_sync_reg[two_wire_route_pkg::SCL_BIT];
      clk_in_reg <= 1'b1;
    end else begin
      rx_in_reg  <= pin_sync_reg[two_wire_route_pkg::SCL_BIT];
      sda_in_reg <= 1'b1;
      scl_in_reg <= 1'b1;
      clk_in_reg <= pin_sync_reg[two_wire_route_pkg::CLKP_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign serial_receive_in   = rx_in_reg;
  assign serial_sda_in       = sda_in_reg;
  assign serial_scl_in       = scl_in_reg;
  assign serial_clock_pin_in = clk_in_reg;

  assign cpu_port_rdata      = rdata_reg;
  assign port_latch_out      = port_latch_reg;
  assign port_dir_out        = port_dir_reg;

  assign irq_src_a           = irq_a_reg;
  assign irq_src_b           = irq_b_reg;
  assign irq_src_c           = irq_c_reg;
  assign dma_channel_one_req = dma_reg;
  assign two_wire_active     = is_two_wire;

  assign port_pin_out        = pin_out_reg;
  assign port_pin_oe         = pin_oe_reg;

endmodule // i2c_mode_pin_irq_routing

// File: design/link_event_sync.sv
`timescale 1ns/100ps
module link_event_sync (
  input  wire logic                                 link_clk,
  input  wire logic                                 clk,
  input  wire logic                                 sys_rst,
  input  wire logic [two_wire_route_pkg::EVT_N-1:0] link_evt,
  event_bus_if.producer                             bus
);

  logic [two_wire_route_pkg::EVT_N-1:0] tog_reg;
  logic [two_wire_route_pkg::EVT_N-1:0] meta_reg;
  logic [two_wire_route_pkg::EVT_N-1:0] sync_reg;
  logic [two_wire_route_pkg::EVT_N-1:0] prev_reg;
  logic [two_wire_route_pkg::EVT_N-1:0] pulse_reg;

  genvar g;
  generate
    for (g = 0; g < two_wire_route_pkg::EVT_N; g = g + 1) begin : g_evt
      // a toggle per event survives any ratio of the two clocks
      always_ff @(posedge link_clk or posedge sys_rst) begin
        if (sys_rst) begin
          tog_reg[g] <= 1'b0;
        end else if (link_evt[g]) begin
          tog_reg[g] <= ~tog_reg[g];
        end
      end

      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          meta_reg[g]  <= 1'b0;
          sync_reg[g]  <= 1'b0;
          prev_reg[g]  <= 1'b0;
          pulse_reg[g] <= 1'b0;
        end else begin
          meta_reg[g]  <= tog_reg[g];
          sync_reg[g]  <= meta_reg[g];
          prev_reg[g]  <= sync_reg[g];
          pulse_reg[g] <= sync_reg[g] ^ prev_reg[g];
        end
      end
    end
  endgenerate

  assign bus.evt_pulse = pulse_reg;

endmodule // link_event_sync

// File: include/event_bus_if.sv
`timescale 1ns/100ps
interface event_bus_if;
  logic [two_wire_route_pkg::EVT_N-1:0] evt_pulse;
  modport producer (output evt_pulse);
  modport consumer (input  evt_pulse);
endinterface

// File: include/two_wire_route_pkg.sv
package two_wire_route_pkg;

  // port geometry
  localparam int unsigned PORT_W    = 8;
  localparam int unsigned SDA_BIT   = 0;
  localparam int unsigned SCL_BIT   = 1;
  localparam int unsigned CLKP_BIT  = 2;

  // reset values of the port latch and direction register (0 = input)
  localparam logic [7:0] LATCH_RST  = 8'h00;
  localparam logic [7:0] DIR_RST    = 8'h00;

  // link-side event lines, one bit each
  localparam int unsigned EVT_N          = 6;
  localparam int unsigned EVT_START_STOP = 0;
  localparam int unsigned EVT_COLLISION  = 1;
  localparam int unsigned EVT_NACK       = 2;
  localparam int unsigned EVT_ACK        = 3;
  localparam int unsigned EVT_TX         = 4;
  localparam int unsigned EVT_RX         = 5;

  // dma channel one request selector
  localparam int unsigned DMA_SEL_W      = 4;
  localparam logic [3:0]  DMA_SEL_SERIAL = 4'hd;

  // interrupt source numbers carried by the three request outputs
  localparam int unsigned IRQ_NUM_A = 10;
  localparam int unsigned IRQ_NUM_B = 15;
  localparam int unsigned IRQ_NUM_C = 16;

  typedef enum logic {
    MODE_SYNC_SERIAL,
    MODE_TWO_WIRE
  } serial_mode_t;

endpackage
